// ===== shared/mbs_pkg.sv
package mbs_pkg;

    // Clock and serial timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int CLK_HZ = 50_000_000;
    localparam int BAUD_RATE = 19200;
    localparam int DATA_BITS = 8;
    localparam logic [15:0] BIT_CYCLES = 16'(CLK_HZ / BAUD_RATE);
    localparam logic [15:0] HALF_BIT_CYCLES = 16'(CLK_HZ / BAUD_RATE / 2);
    localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);

    // Frame end silence: 3.5 characters of 10 bits each
    localparam int T35_NS = 1_822_917;
    localparam int T35_CYCLES = (T35_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // One second of the time counter
    localparam int SECOND_NS = 1_000_000_000;
    localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

    // Protocol constants
    localparam logic [7:0] FC_READ_HOLD = 8'h03;
    localparam logic [3:0] REQ_LEN = 4'h8;
    localparam logic [3:0] REQ_OVER = 4'h9;
    localparam logic [7:0] MAX_REG_COUNT = 8'h7d;
    localparam logic [8:0] REPLY_OVERHEAD = 9'h005;
    localparam logic [8:0] REPLY_BODY_START = 9'h003;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [15:0] CRC_GOOD = 16'h0000;

    // Holding register indices, zero based
    localparam logic [15:0] REG_EPOCH_HIGH = 16'h0004;
    localparam logic [15:0] REG_EPOCH_LOW = 16'h0005;
    localparam logic [15:0] REG_FAULT_STATUS = 16'h0007;
    localparam logic [15:0] REG_HEALTH_CODE = 16'h0009;
    localparam logic [15:0] REG_MOTOR_SPEED = 16'h000a;
    localparam logic [15:0] REG_MOTOR_DIR = 16'h000b;
    localparam logic [15:0] REG_MOTOR_CURRENT = 16'h000c;
    localparam logic [15:0] REG_BATTERY_VOLT = 16'h000d;
    localparam logic [15:0] REG_CHARGE_CURRENT = 16'h000e;

    typedef enum logic [1:0] {
        ST_LISTEN = 2'b00,
        ST_CHECK = 2'b01,
        ST_REPLY = 2'b10
    } mbs_state_t;

    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_START = 2'b01,
        SER_DATA = 2'b10,
        SER_STOP = 2'b11
    } mbs_ser_t;

    // Modbus CRC-16, one byte, reflected polynomial
    function automatic logic [15:0] mbs_crc_step(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int i = 0; i < DATA_BITS; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

endpackage

// ===== shared/mbs_link_if.sv
`timescale 1ns/100ps
interface mbs_link_if;
    logic [7:0] rx_data;
    logic rx_valid;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_ready;

    modport uart (
        output rx_data,
        output rx_valid,
        output tx_ready,
        input tx_data,
        input tx_valid
    );

    modport core (
        input rx_data,
        input rx_valid,
        input tx_ready,
        output tx_data,
        output tx_valid
    );
endinterface

// ===== rtl/mbs_uart.sv
`timescale 1ns/100ps
module mbs_uart import mbs_pkg::*; #(
    parameter logic [15:0] BIT_CYC = BIT_CYCLES,
    parameter logic [15:0] HALF_CYC = HALF_BIT_CYCLES
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic rxd_in,
    output logic txd_out,
    mbs_link_if.uart link
);

    typedef struct packed {
        mbs_ser_t rx_st;
        logic [15:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic [7:0] rx_data;
        logic rx_valid;
        mbs_ser_t tx_st;
        logic [15:0] tx_cnt;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic txd;
    } mbs_uart_t;

    mbs_uart_t s;
    mbs_uart_t next_s;

    assign link.rx_data = s.rx_data;
    assign link.rx_valid = s.rx_valid;
    assign link.tx_ready = (s.tx_st == SER_IDLE);
    assign txd_out = s.txd;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        next_s.rx_valid = 1'b0;
        // R1: receive 8N1 character
        case (s.rx_st)
            SER_IDLE: begin
                next_s.rx_cnt = '0;
                if (!rxd_in) begin
                    next_s.rx_st = SER_START;
                end
            end
            SER_START: begin
                if (s.rx_cnt == HALF_CYC - 16'h0001) begin
                    next_s.rx_cnt = '0;
                    next_s.rx_bit = '0;
                    next_s.rx_st = rxd_in ? SER_IDLE : SER_DATA;
                end else begin
                    next_s.rx_cnt = s.rx_cnt + 16'h0001;
                end
            end
            SER_DATA: begin
                if (s.rx_cnt == BIT_CYC - 16'h0001) begin
                    next_s.rx_cnt = '0;
                    next_s.rx_sh = {rxd_in, s.rx_sh[7:1]};
                    if (s.rx_bit == LAST_BIT) begin
                        next_s.rx_st = SER_STOP;
                    end else begin
                        next_s.rx_bit = s.rx_bit + 3'h1;
                    end
                end else begin
                    next_s.rx_cnt = s.rx_cnt + 16'h0001;
                end
            end
            SER_STOP: begin
                if (s.rx_cnt == BIT_CYC - 16'h0001) begin
                    next_s.rx_st = SER_IDLE;
                    if (rxd_in) begin
                        next_s.rx_data = s.rx_sh;
                        next_s.rx_valid = 1'b1;
                    end
                end else begin
                    next_s.rx_cnt = s.rx_cnt + 16'h0001;
                end
            end
            default: next_s.rx_st = SER_IDLE;
        endcase
        // R1: transmit 8N1 character
        case (s.tx_st)
            SER_IDLE: begin
                next_s.txd = 1'b1;
                next_s.tx_cnt = '0;
                if (link.tx_valid) begin
                    next_s.tx_sh = link.tx_data;
                    next_s.tx_st = SER_START;
                    next_s.txd = 1'b0;
                end
            end
            SER_START: begin
                if (s.tx_cnt == BIT_CYC - 16'h0001) begin
                    next_s.tx_cnt = '0;
                    next_s.tx_bit = '0;
                    next_s.tx_st = SER_DATA;
                    next_s.txd = s.tx_sh[0];
                end else begin
                    next_s.tx_cnt = s.tx_cnt + 16'h0001;
                end
            end
            SER_DATA: begin
                if (s.tx_cnt == BIT_CYC - 16'h0001) begin
                    next_s.tx_cnt = '0;
                    next_s.tx_sh = {1'b0, s.tx_sh[7:1]};
                    if (s.tx_bit == LAST_BIT) begin
                        next_s.tx_st = SER_STOP;
                        next_s.txd = 1'b1;
                    end else begin
                        next_s.tx_bit = s.tx_bit + 3'h1;
                        next_s.txd = s.tx_sh[1];
                    end
                end else begin
                    next_s.tx_cnt = s.tx_cnt + 16'h0001;
                end
            end
            SER_STOP: begin
                next_s.txd = 1'b1;
                if (s.tx_cnt == BIT_CYC - 16'h0001) begin
                    next_s.tx_st = SER_IDLE;
                end else begin
                    next_s.tx_cnt = s.tx_cnt + 16'h0001;
                end
            end
            default: next_s.tx_st = SER_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s <= '0;
            s.txd <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_TX_START_BIT: assert property (@(posedge clk_in) disable iff (reset_in) // R1
        (link.tx_valid && link.tx_ready) |=> !txd_out [*8])
        else $error("Start bit not driven low");

    AST_TX_STOP_HIGH: assert property (@(posedge clk_in) disable iff (reset_in) // R1
        (s.tx_st == SER_STOP || s.tx_st == SER_IDLE) |-> txd_out)
        else $error("Line not high in stop or idle");

endmodule

// ===== rtl/mbs_slave.sv
// Behaviour
// R1: 19200 baud, 8N1, no flow control
// R2: Slave only, answers own identifier
// R3: Identifier replaceable from memory card load
// R4: Supports function 3, read holding registers
// R5: Valid request gets reply with register data
// R6: Request: address, 3, start, count, CRC
// R7: Reply: address, 3, byte count, data, CRC
// R8: Master keeps inter-byte gap under 20 ms
// R9: Master spaces requests at least 50 ms
// R10: Master polls slaves one at a time
// R11: Register indices are zero based decimal
// R12: Time split: register 4 high, 5 low
// R13: Time counts seconds since 1970 UTC
// R14: Time set from positioning receiver
// R15: Registers expose fault, health, motor, battery
// R16: Register 7 holds subsystem error bits
// R17: Register 9 holds health indicator code
// R18: Registers 10, 11 motor speed, direction
// R19: Registers 12-14 current, voltage, charge current
// R20: CRC-16 low byte first; bad frames dropped
// R21: 3.5 character silence ends a frame
`timescale 1ns/100ps
module mbs_slave import mbs_pkg::*; #(
    parameter int T35_CYC = T35_CYCLES,
    parameter int SEC_CYC = SECOND_CYCLES,
    parameter logic [7:0] MAX_REGS = MAX_REG_COUNT,
    parameter logic [15:0] BIT_CYC = BIT_CYCLES,
    parameter logic [15:0] HALF_CYC = HALF_BIT_CYCLES
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic rxd_in,
    input wire logic [7:0] slave_id_in,
    input wire logic [7:0] card_id_in,
    input wire logic card_id_load_in,
    input wire logic [31:0] epoch_in,
    input wire logic epoch_load_in,
    input wire logic [15:0] fault_status_in,
    input wire logic [15:0] health_code_in,
    input wire logic [15:0] motor_speed_in,
    input wire logic [1:0] motor_dir_in,
    input wire logic [15:0] motor_current_in,
    input wire logic [15:0] battery_voltage_in,
    input wire logic [15:0] charge_current_in,
    output logic txd_out,
    output logic [7:0] slave_id_out,
    output logic frame_ok_out,
    output logic frame_drop_out
);

    typedef struct packed {
        mbs_state_t state;
        logic [7:0] id;
        logic id_loaded;
        logic [31:0] epoch;
        logic [31:0] sec_cnt;
        logic [31:0] snap;
        logic [31:0] quiet;
        logic [3:0] rx_cnt;
        logic [7:0][7:0] frame;
        logic [15:0] crc;
        logic [15:0] start;
        logic [7:0] count;
        logic [8:0] idx;
        logic [7:0] tx_data;
        logic tx_valid;
        logic frame_ok;
        logic frame_drop;
    } mbs_core_t;

    mbs_core_t s;
    mbs_core_t next_s;
    mbs_link_if link ();
    logic good;
    logic accept;
    logic [8:0] total;
    logic [8:0] j;
    logic [15:0] crc_n;

    assign link.tx_data = s.tx_data;
    assign link.tx_valid = s.tx_valid;
    assign slave_id_out = s.id;
    assign frame_ok_out = s.frame_ok;
    assign frame_drop_out = s.frame_drop;

    mbs_uart #(.BIT_CYC(BIT_CYC), .HALF_CYC(HALF_CYC)) u_uart (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .rxd_in(rxd_in),
        .txd_out(txd_out),
        .link(link)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register map read
    function automatic logic [15:0] reg_value(input logic [15:0] idx, input logic [31:0] tm);
        logic [15:0] v;
        // R15: status register set
        // R11: zero based index decode
        case (idx)
            // R12: time split high, low
            REG_EPOCH_HIGH: v = tm[31:16];
            REG_EPOCH_LOW: v = tm[15:0];
            // R16: subsystem error bits
            REG_FAULT_STATUS: v = fault_status_in;
            // R17: health indicator code
            REG_HEALTH_CODE: v = health_code_in;
            // R18: motor speed, direction
            REG_MOTOR_SPEED: v = motor_speed_in;
            REG_MOTOR_DIR: v = {14'h0000, motor_dir_in};
            // R19: current and battery values
            REG_MOTOR_CURRENT: v = motor_current_in;
            REG_BATTERY_VOLT: v = battery_voltage_in;
            REG_CHARGE_CURRENT: v = charge_current_in;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // Reply byte before the CRC
    function automatic logic [7:0] body_byte(input logic [8:0] k, input mbs_core_t c);
        logic [8:0] d;
        logic [15:0] v;
        d = k - REPLY_BODY_START;
        v = reg_value(c.start + {7'h00, d[8:1]}, c.snap);
        // R7: reply field order
        case (k)
            9'h000: return c.id;
            9'h001: return FC_READ_HOLD;
            9'h002: return {c.count[6:0], 1'b0};
            default: return d[0] ? v[7:0] : v[15:8];
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        next_s.frame_ok = 1'b0;
        next_s.frame_drop = 1'b0;
        accept = s.tx_valid && link.tx_ready;
        total = {s.count, 1'b0} + REPLY_OVERHEAD;
        j = s.idx + 9'h001;
        crc_n = s.crc;
        // R4: address, function, count and CRC check
        good = (s.rx_cnt == REQ_LEN) && (s.frame[0] == s.id) && (s.frame[1] == FC_READ_HOLD)
            && (s.crc == CRC_GOOD) && (s.frame[4] == 8'h00) && (s.frame[5] != 8'h00)
            && (s.frame[5] <= MAX_REGS);

        // R2: manufacture identifier after reset
        if (!s.id_loaded) begin
            next_s.id = slave_id_in;
            next_s.id_loaded = 1'b1;
        // R3: identifier from memory card
        end else if (card_id_load_in) begin
            next_s.id = card_id_in;
        end

        // R14: receiver sets time
        if (epoch_load_in) begin
            next_s.epoch = epoch_in;
            next_s.sec_cnt = '0;
        // R13: count whole seconds
        end else if (s.sec_cnt == 32'(SEC_CYC - 1)) begin
            next_s.sec_cnt = '0;
            next_s.epoch = s.epoch + 32'h0000_0001;
        end else begin
            next_s.sec_cnt = s.sec_cnt + 32'h0000_0001;
        end

        case (s.state)
            ST_LISTEN: begin
                if (link.rx_valid) begin
                    next_s.quiet = '0;
                    if (s.rx_cnt < REQ_LEN) begin
                        next_s.frame[s.rx_cnt[2:0]] = link.rx_data;
                        // R20: running CRC over frame
                        next_s.crc = mbs_crc_step(s.crc, link.rx_data);
                        next_s.rx_cnt = s.rx_cnt + 4'h1;
                    end else begin
                        next_s.rx_cnt = REQ_OVER;
                    end
                end else if (s.quiet != 32'(T35_CYC)) begin
                    next_s.quiet = s.quiet + 32'h0000_0001;
                // R21: silence ends frame
                end else if (s.rx_cnt != 4'h0) begin
                    next_s.state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                next_s.rx_cnt = '0;
                next_s.crc = CRC_INIT;
                // R5: answer good request
                if (good) begin
                    next_s.frame_ok = 1'b1;
                    next_s.start = {s.frame[2], s.frame[3]};
                    next_s.count = s.frame[5];
                    next_s.snap = s.epoch;
                    next_s.idx = '0;
                    next_s.tx_data = s.id;
                    next_s.tx_valid = 1'b1;
                    next_s.state = ST_REPLY;
                // R20: silent discard
                end else begin
                    next_s.frame_drop = 1'b1;
                    next_s.quiet = '0;
                    next_s.state = ST_LISTEN;
                end
            end
            ST_REPLY: begin
                if (accept) begin
                    if (s.idx < total - 9'h002) begin
                        crc_n = mbs_crc_step(s.crc, s.tx_data);
                    end
                    next_s.crc = crc_n;
                    next_s.idx = j;
                    // R7: data then CRC
                    if (j < total - 9'h002) begin
                        next_s.tx_data = body_byte(j, s);
                    // R20: CRC low byte first
                    end else if (j == total - 9'h002) begin
                        next_s.tx_data = crc_n[7:0];
                    end else if (j == total - 9'h001) begin
                        next_s.tx_data = crc_n[15:8];
                    end else begin
                        next_s.tx_valid = 1'b0;
                        next_s.crc = CRC_INIT;
                        next_s.quiet = '0;
                        next_s.state = ST_LISTEN;
                    end
                end
            end
            default: next_s.state = ST_LISTEN;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s <= '0;
            s.crc <= CRC_INIT;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_STRAP_ID: assert property (@(posedge clk_in) disable iff (reset_in) // R2
        (!s.id_loaded) |=> (s.id == $past(slave_id_in)) && s.id_loaded)
        else $error("Identifier not taken after reset");

    AST_CARD_ID: assert property (@(posedge clk_in) disable iff (reset_in) // R3
        (s.id_loaded && card_id_load_in) |=> s.id == $past(card_id_in))
        else $error("Card identifier not loaded");

    AST_FUNC_BYTE: assert property (@(posedge clk_in) disable iff (reset_in) // R4
        (s.state == ST_REPLY && s.idx == 9'h001) |-> s.tx_data == FC_READ_HOLD)
        else $error("Function byte wrong in reply");

    AST_GOOD_REPLY: assert property (@(posedge clk_in) disable iff (reset_in) // R5
        (s.state == ST_CHECK && good) |=> (s.state == ST_REPLY) && s.tx_valid && frame_ok_out)
        else $error("Good request not answered");

    AST_REPLY_HEAD: assert property (@(posedge clk_in) disable iff (reset_in) // R7
        (s.state == ST_CHECK && good) |=> (s.tx_data == s.id) && (s.idx == 9'h000)
        && (s.count == $past(s.frame[5])))
        else $error("Reply does not open with address");

    AST_BYTE_COUNT: assert property (@(posedge clk_in) disable iff (reset_in) // R7
        (s.state == ST_REPLY && s.idx == 9'h002) |-> s.tx_data == {s.count[6:0], 1'b0})
        else $error("Byte count wrong in reply");

    AST_EPOCH_SPLIT: assert property (@(posedge clk_in) disable iff (reset_in) // R12
        (s.state == ST_REPLY && s.idx == REPLY_BODY_START && s.start == REG_EPOCH_HIGH)
        |-> s.tx_data == s.snap[31:24])
        else $error("Time halves do not rebuild value");

    AST_EPOCH_TICK: assert property (@(posedge clk_in) disable iff (reset_in) // R13
        (!epoch_load_in && s.sec_cnt == 32'(SEC_CYC - 1)) |=> s.epoch == $past(s.epoch) + 32'h0000_0001)
        else $error("Seconds count did not advance");

    AST_EPOCH_LOAD: assert property (@(posedge clk_in) disable iff (reset_in) // R14
        epoch_load_in |=> (s.epoch == $past(epoch_in)) && (s.sec_cnt == 32'h0000_0000))
        else $error("Time not loaded from receiver");

    AST_CRC_DROP: assert property (@(posedge clk_in) disable iff (reset_in) // R20
        (s.state == ST_CHECK && s.crc != CRC_GOOD) |=> (s.state == ST_LISTEN) && frame_drop_out && !s.tx_valid)
        else $error("Bad CRC frame not discarded");

    AST_QUIET_END: assert property (@(posedge clk_in) disable iff (reset_in) // R21
        (s.state == ST_LISTEN && next_s.state == ST_CHECK) |-> s.quiet == 32'(T35_CYC))
        else $error("Frame ended before silence time");

endmodule

// ===== sim/mbs_master_model.sv
`timescale 1ns/100ps
module mbs_master_model import mbs_pkg::*; #(
    parameter int BIT_LEN = int'(BIT_CYCLES),
    parameter int HALF_LEN = int'(HALF_BIT_CYCLES),
    parameter int LIMIT = 40000
) (
    input wire logic clk_in,
    input wire logic line_in,
    output logic line_out
);
    initial begin
        line_out = 1'b1;
    end

    ////////////////////////////////////////////////////////////////
    // reflected crc over a byte queue
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
            end
        end
        return c;
    endfunction

    // start, eight bits lsb first, one stop
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_in);
            #1 line_out = f[i];
            repeat (BIT_LEN - 1) @(posedge clk_in);
        end
    endtask

    // request fields, bytes back to back, crc low first
    task automatic send_frame(input logic [7:0] q[$], input logic [15:0] flip);
        logic [15:0] c;
        c = crc16(q) ^ flip;
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[i]) begin
            send_byte(q[i]);
        end
    endtask

    // receive one character, bounded wait for start
    task automatic recv_byte(output logic [7:0] b, output logic ok);
        ok = 1'b0;
        b = 8'h00;
        for (int n = 0; n < LIMIT && !ok; n++) begin
            @(posedge clk_in);
            ok = (line_in === 1'b0);
        end
        if (ok) begin
            repeat (HALF_LEN) @(posedge clk_in);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_LEN) @(posedge clk_in);
                b[i] = line_in;
            end
            repeat (BIT_LEN) @(posedge clk_in);
            ok = (line_in === 1'b1);
        end
    endtask
endmodule

// ===== sim/mbs_slave_test.sv
`timescale 1ns/100ps
module mbs_slave_test import mbs_pkg::*;;
    localparam int BIT_LEN = 16;
    localparam int T35 = 600;
    localparam int GAP = 4 * T35;
    localparam int LIMIT = 2000;
    localparam int SEC = 1000;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic rxd, txd, card_load, epoch_load, ok_p, drop_p;
    logic [7:0] strap, card_id, id_out;
    logic [31:0] epoch, lfsr, tm, tm_prev, snap_m;
    logic [15:0] fault, health, speed, mcur, bvolt, ccur;
    logic [1:0] dir;
    int errors = 0;
    int checks_done = 0;
    int ok_cnt = 0;
    int drop_cnt = 0;
    int tm_cnt = 0;

    initial begin
        forever #10 clk_in = ~clk_in;
    end

    mbs_master_model #(.BIT_LEN(BIT_LEN), .HALF_LEN(BIT_LEN / 2), .LIMIT(LIMIT)) master (.clk_in(clk_in),
        .line_in(txd), .line_out(rxd));

    mbs_slave #(.T35_CYC(T35), .SEC_CYC(SEC), .BIT_CYC(16'(BIT_LEN)), .HALF_CYC(16'(BIT_LEN / 2))) DUT (
        .clk_in(clk_in), .reset_in(reset_in),
        .rxd_in(rxd), .slave_id_in(strap), .card_id_in(card_id), .card_id_load_in(card_load),
        .epoch_in(epoch), .epoch_load_in(epoch_load), .fault_status_in(fault),
        .health_code_in(health), .motor_speed_in(speed), .motor_dir_in(dir),
        .motor_current_in(mcur), .battery_voltage_in(bvolt), .charge_current_in(ccur),
        .txd_out(txd), .slave_id_out(id_out), .frame_ok_out(ok_p), .frame_drop_out(drop_p));

    always @(posedge clk_in) begin
        ok_cnt <= ok_cnt + int'(ok_p === 1'b1);
        drop_cnt <= drop_cnt + int'(drop_p === 1'b1);
        tm_prev <= tm;
        if (reset_in) begin
            tm <= '0;
            tm_cnt <= 0;
        end else if (epoch_load) begin
            tm <= epoch;
            tm_cnt <= 0;
        end else if (tm_cnt == SEC - 1) begin
            tm <= tm + 32'h1;
            tm_cnt <= 0;
        end else begin
            tm_cnt <= tm_cnt + 1;
        end
    end

    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic rnd_fill();
        for (int i = 0; i < 9; i++) begin
            lfsr = lfsr_next(lfsr);
            case (i)
                0: fault = lfsr[15:0];
                1: health = lfsr[15:0];
                2: speed = lfsr[15:0];
                3: mcur = lfsr[15:0];
                4: bvolt = lfsr[15:0];
                5: ccur = lfsr[15:0];
                6: dir = (lfsr[1:0] == 2'h2) ? 2'h3 : lfsr[1:0];
                7: card_id = lfsr[7:0];
                default: epoch = lfsr;
            endcase
        end
    endtask

    function automatic logic [15:0] reg_model(input int idx);
        case (idx)
            4: return snap_m[31:16];
            5: return snap_m[15:0];
            7: return fault;
            9: return health;
            10: return speed;
            11: return {14'h0000, dir};
            12: return mcur;
            13: return bvolt;
            14: return ccur;
            default: return 16'h0000;
        endcase
    endfunction

    task automatic final_report();
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic transact(input logic [7:0] id, input logic [7:0] fc, input int start, input int cnt,
        input logic [15:0] flip, input logic answered);
        logic [7:0] q[$];
        logic [7:0] e[$];
        logic [7:0] b;
        logic got;
        logic [15:0] v;
        int ok0;
        int drop0;
        ok0 = ok_cnt;
        drop0 = drop_cnt;
        q = {id, fc, 8'(start >> 8), 8'(start), 8'h00, 8'(cnt)};
        master.send_frame(q, flip);
        if (answered) begin
            for (int n = 0; n < LIMIT && ok_p !== 1'b1; n++) begin
                @(posedge clk_in);
            end
            snap_m = tm_prev;
            e = {id, 8'h03, 8'(2 * cnt)};
            for (int r = start; r < start + cnt; r++) begin
                v = reg_model(r);
                e.push_back(v[15:8]);
                e.push_back(v[7:0]);
            end
            v = master.crc16(e);
            e.push_back(v[7:0]);
            e.push_back(v[15:8]);
        end
        foreach (e[i]) begin
            master.recv_byte(b, got);
            if (got !== 1'b1) begin
                errors++;
                final_report();
            end
            check({24'h0, b}, {24'h0, e[i]});
        end
        master.recv_byte(b, got);
        check({31'h0, got}, 32'h0);
        check(32'(ok_cnt - ok0), {31'h0, answered});
        check(32'(drop_cnt - drop0), {31'h0, !answered});
        repeat (GAP) @(posedge clk_in);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] bad_fc[5] = '{8'h03, 8'h04, 8'h03, 8'h03, 8'h03};
        int bad_cnt[5] = '{1, 1, 1, 0, 126};
        logic [15:0] bad_flip[5] = '{16'h0000, 16'h0000, 16'h0100, 16'h0000, 16'h0000};
        lfsr = 32'h78e0;
        card_load = 1'b0;
        epoch_load = 1'b0;
        rnd_fill();
        strap = lfsr[23:16];
        repeat (12) @(posedge clk_in);
        #1 reset_in = 1'b0;
        repeat (3) @(posedge clk_in);
        #1 check({24'h0, id_out}, {24'h0, strap});
        epoch_load = 1'b1;
        @(posedge clk_in);
        #1 epoch_load = 1'b0;
        transact(strap, FC_READ_HOLD, 4, 2, 16'h0000, 1'b1);
        for (int i = 0; i < 5; i++) begin
            transact(strap ^ {7'h00, i == 0}, bad_fc[i], 4, bad_cnt[i], bad_flip[i], 1'b0);
        end
        rnd_fill();
        card_load = 1'b1;
        epoch_load = 1'b1;
        @(posedge clk_in);
        #1 card_load = 1'b0;
        epoch_load = 1'b0;
        @(posedge clk_in);
        #1 check({24'h0, id_out}, {24'h0, card_id});
        transact(card_id, FC_READ_HOLD, 7, 8, 16'h0000, 1'b1);
        transact(card_id, FC_READ_HOLD, 0, 6, 16'h0000, 1'b1);
        final_report();
    end
endmodule
